// [core/mdb_baud_gen.sv]
// baud generator: one tick per divisor clocks, sixteen ticks per bit
// assumes a divisor held steady while frames are in flight
`timescale 1ns/100ps
`default_nettype none
`include "mdb_uart_defines.svh"

module mdb_baud_gen
	import mdb_uart_pkg::*;
(
	input  wire logic                  sys_clk_i,
	input  wire logic                  srst_i,
	input  wire logic [`MDB_DIV_W-1:0] baud_divisor_i,
	output logic                       tick_16x_o
);

	mdb_brg_state_t st_ff;
	mdb_brg_state_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		// divisor zero parks the generator rather than ticking every clock
		if (baud_divisor_i == `MDB_DIV_RST)
			nxt_st.cnt = '0;
		else if (st_ff.cnt >= baud_divisor_i - `MDB_DIV_W'(1))
		begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.cnt = st_ff.cnt + `MDB_DIV_W'(1);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign tick_16x_o = st_ff.tick;

	sequence seq_gap_of_three;
		!tick_16x_o ##1 !tick_16x_o ##1 tick_16x_o;
	endsequence

	chk_tick_spacing_three: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(tick_16x_o && baud_divisor_i == 16'h0003 && $stable(baud_divisor_i)) ##1 $stable(baud_divisor_i)
		|-> seq_gap_of_three)
		else $error("baud tick spacing differs from divisor");

endmodule

`default_nettype wire

// [core/mdb_uart.sv]
// multidrop uart: transmitter, receiver, nine-bit address filter, driver enable
// assumes rxd_i is asynchronous; configuration inputs come from logic on sys_clk_i
`timescale 1ns/100ps
`default_nettype none
`include "mdb_uart_defines.svh"

module mdb_uart
	import mdb_uart_pkg::*;
(
	input  wire logic                  sys_clk_i,
	input  wire logic                  srst_i,
	input  wire mdb_cfg_t              cfg_i,
	input  wire logic [`MDB_DIV_W-1:0] baud_divisor_i,
	input  wire logic                  tx_valid_i,
	input  wire logic [7:0]            tx_data_i,
	output logic                       tx_ready_o,
	input  wire logic                  rxd_i,
	output logic                       txd_o,
	output logic                       line_driver_enable_o,
	output mdb_rx_out_t                rx_o
);

	mdb_state_t st_ff;
	mdb_state_t nxt_st;
	logic       tick_16x;
	logic       tx_adv;
	logic       rx_adv;
	logic       tx_accept;
	logic       rx_is_addr;
	logic       rx_hit;

	mdb_baud_gen u_baud_gen (
		.sys_clk_i      (sys_clk_i),
		.srst_i         (srst_i),
		.baud_divisor_i (baud_divisor_i),
		.tick_16x_o     (tick_16x)
	);

	assign tx_ready_o = (st_ff.tx_state == MDB_TX_IDLE);
	assign tx_accept = tx_ready_o && tx_valid_i;
	assign tx_adv = tick_16x && (st_ff.tx_sub == `MDB_SUB_LAST);
	// start bit is checked at its middle, every later bit one full bit after that
	assign rx_adv = tick_16x && (st_ff.rx_sub == ((st_ff.rx_state == MDB_RX_START) ? `MDB_SUB_MID : `MDB_SUB_LAST));
	assign rx_is_addr = st_ff.rx_nine && st_ff.rx_ninth;
	assign rx_hit = rx_is_addr && (st_ff.rx_shift == cfg_i.addr_compare);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rx_out.valid = 1'b0;
		nxt_st.rx_out.irq = 1'b0;
		// the first stage feeds only the second
		nxt_st.rx_sync1 = rxd_i;
		nxt_st.rx_sync2 = st_ff.rx_sync1;
		nxt_st.rx_prev = st_ff.rx_sync2;

		if (tick_16x && st_ff.tx_state != MDB_TX_IDLE)
			nxt_st.tx_sub = st_ff.tx_sub + 4'h1;
		unique case (st_ff.tx_state)
			MDB_TX_IDLE:
				if (tx_valid_i)
				begin
					nxt_st.tx_state = MDB_TX_START;
					nxt_st.tx_sub = 4'h0;
					nxt_st.tx_bit = 3'h0;
					nxt_st.txd = 1'b0;
					nxt_st.tx_shift = tx_data_i;
					nxt_st.tx_nine = cfg_i.nine_bit_mode_on;
					nxt_st.tx_ninth = cfg_i.nine_bit_mode_on & cfg_i.ninth_bit_tx_value;
					nxt_st.tx_par_on = cfg_i.parity_on & ~cfg_i.nine_bit_mode_on;
					nxt_st.tx_par = (^tx_data_i) ^ cfg_i.parity_odd;
				end
			MDB_TX_START:
				if (tx_adv)
				begin
					nxt_st.tx_state = MDB_TX_DATA;
					nxt_st.txd = st_ff.tx_shift[0];
				end
			MDB_TX_DATA:
				if (tx_adv)
				begin
					if (st_ff.tx_bit == `MDB_BIT_LAST)
					begin
						if (st_ff.tx_nine)
						begin
							nxt_st.tx_state = MDB_TX_NINTH;
							nxt_st.txd = st_ff.tx_ninth;
						end
						else if (st_ff.tx_par_on)
						begin
							nxt_st.tx_state = MDB_TX_PARITY;
							nxt_st.txd = st_ff.tx_par;
						end
						else
						begin
							nxt_st.tx_state = MDB_TX_STOP;
							nxt_st.txd = `MDB_LINE_IDLE;
						end
					end
					else
					begin
						nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
						nxt_st.tx_shift = {1'b0, st_ff.tx_shift[7:1]};
						nxt_st.txd = st_ff.tx_shift[1];
					end
				end
			MDB_TX_NINTH, MDB_TX_PARITY:
				if (tx_adv)
				begin
					nxt_st.tx_state = MDB_TX_STOP;
					nxt_st.txd = `MDB_LINE_IDLE;
				end
			MDB_TX_STOP:
				if (tx_adv)
					nxt_st.tx_state = MDB_TX_IDLE;
		endcase
		// enable spans start bit to end of stop bit
		nxt_st.de = (nxt_st.tx_state != MDB_TX_IDLE) ^ cfg_i.driver_enable_polarity;

		if (tick_16x && st_ff.rx_state != MDB_RX_IDLE)
			nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
		unique case (st_ff.rx_state)
			MDB_RX_IDLE:
				if (st_ff.rx_prev && !st_ff.rx_sync2)
				begin
					nxt_st.rx_state = MDB_RX_START;
					nxt_st.rx_sub = 4'h0;
				end
			MDB_RX_START:
				if (rx_adv)
				begin
					// a glitch shorter than half a bit is not a start bit
					if (st_ff.rx_sync2)
						nxt_st.rx_state = MDB_RX_IDLE;
					else
					begin
						nxt_st.rx_state = MDB_RX_DATA;
						nxt_st.rx_sub = 4'h0;
						nxt_st.rx_bit = 3'h0;
						nxt_st.rx_nine = cfg_i.nine_bit_mode_on;
						nxt_st.rx_ninth = 1'b0;
						nxt_st.rx_par_on = cfg_i.parity_on & ~cfg_i.nine_bit_mode_on;
						nxt_st.rx_par_bad = 1'b0;
					end
				end
			MDB_RX_DATA:
				if (rx_adv)
				begin
					nxt_st.rx_shift = {st_ff.rx_sync2, st_ff.rx_shift[7:1]};
					nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
					if (st_ff.rx_bit == `MDB_BIT_LAST)
					begin
						if (st_ff.rx_nine)
							nxt_st.rx_state = MDB_RX_NINTH;
						else if (st_ff.rx_par_on)
							nxt_st.rx_state = MDB_RX_PARITY;
						else
							nxt_st.rx_state = MDB_RX_STOP;
					end
				end
			MDB_RX_NINTH:
				if (rx_adv)
				begin
					nxt_st.rx_ninth = st_ff.rx_sync2;
					nxt_st.rx_state = MDB_RX_STOP;
				end
			MDB_RX_PARITY:
				if (rx_adv)
				begin
					nxt_st.rx_par_bad = (^st_ff.rx_shift) ^ st_ff.rx_sync2 ^ cfg_i.parity_odd;
					nxt_st.rx_state = MDB_RX_STOP;
				end
			MDB_RX_STOP:
				if (rx_adv)
				begin
					// back to idle at mid stop bit so a tight next start is seen
					nxt_st.rx_state = MDB_RX_IDLE;
					nxt_st.rx_out.valid = 1'b1;
					nxt_st.rx_out.data = st_ff.rx_shift;
					nxt_st.rx_out.is_addr = rx_is_addr;
					nxt_st.rx_out.frame_err = ~st_ff.rx_sync2;
					nxt_st.rx_out.parity_err = st_ff.rx_par_on & st_ff.rx_par_bad;
					if (!st_ff.rx_nine)
						nxt_st.rx_out.irq = 1'b1;
					else
					begin
						unique case (cfg_i.addr_match_irq_select)
							`MDB_SEL_ALL:
								nxt_st.rx_out.irq = 1'b1;
							`MDB_SEL_ADDR:
								nxt_st.rx_out.irq = rx_is_addr;
							`MDB_SEL_MATCH_FLW:
								if (rx_is_addr)
								begin
									nxt_st.rx_out.irq = rx_hit;
									nxt_st.matched = rx_hit;
								end
								else
									nxt_st.rx_out.irq = st_ff.matched;
							`MDB_SEL_MATCH_DATA:
								if (rx_is_addr)
									nxt_st.matched = rx_hit;
								else
									nxt_st.rx_out.irq = st_ff.matched;
						endcase
					end
				end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			st_ff <= '0;
			st_ff.txd <= `MDB_LINE_IDLE;
			st_ff.de <= `MDB_DE_RST;
			st_ff.rx_sync1 <= `MDB_LINE_IDLE;
			st_ff.rx_sync2 <= `MDB_LINE_IDLE;
			st_ff.rx_prev <= `MDB_LINE_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	assign txd_o = st_ff.txd;
	assign line_driver_enable_o = st_ff.de;
	assign rx_o = st_ff.rx_out;

	sequence seq_start_to_data;
		st_ff.rx_state == MDB_RX_START ##1 st_ff.rx_state == MDB_RX_DATA;
	endsequence

	chk_de_polarity: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		$past(!srst_i) |-> line_driver_enable_o == ((st_ff.tx_state != MDB_TX_IDLE)
		^ $past(cfg_i.driver_enable_polarity)))
		else $error("driver enable level wrong for polarity");

	chk_tx_start_bit: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		tx_accept |=> !txd_o && st_ff.tx_state == MDB_TX_START)
		else $error("frame did not open with a start bit");

	chk_ninth_ignored: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(tx_accept && !cfg_i.nine_bit_mode_on) |=> !st_ff.tx_ninth && !st_ff.tx_nine)
		else $error("ninth bit value used outside nine-bit mode");

	chk_ninth_on_line: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st_ff.tx_state == MDB_TX_NINTH |-> txd_o == st_ff.tx_ninth)
		else $error("ninth bit on line differs from its value");

	chk_no_parity_nine: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st_ff.tx_state == MDB_TX_PARITY |-> !st_ff.tx_nine)
		else $error("parity sent in nine-bit frame");

	chk_rx_mid_sample: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		seq_start_to_data |-> $past(st_ff.rx_sub) == `MDB_SUB_MID && $past(tick_16x) && $past(!st_ff.rx_sync2))
		else $error("start bit not confirmed at its middle");

	chk_rx_class: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		rx_o.valid |-> rx_o.is_addr == $past(st_ff.rx_nine && st_ff.rx_ninth))
		else $error("received byte class not from ninth bit");

	chk_irq_addr_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(rx_o.irq && $past(st_ff.rx_nine) && $past(cfg_i.addr_match_irq_select) == `MDB_SEL_ADDR) |-> rx_o.is_addr)
		else $error("address-only selection raised irq on data");

	chk_irq_match_data: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(rx_o.valid && $past(st_ff.rx_nine) && $past(cfg_i.addr_match_irq_select) == `MDB_SEL_MATCH_DATA)
		|-> rx_o.irq == (!rx_o.is_addr && $past(st_ff.matched)))
		else $error("match-data selection irq wrong");

endmodule

`default_nettype wire

// [core/mdb_uart_defines.svh]
// constants of the multidrop uart: selection codes, sub-bit counts, reset values
// assumes inclusion by bare name from package and design files
`ifndef MDB_UART_DEFINES_SVH
`define MDB_UART_DEFINES_SVH

`define MDB_SEL_ALL        2'h0
`define MDB_SEL_ADDR       2'h1
`define MDB_SEL_MATCH_FLW  2'h2
`define MDB_SEL_MATCH_DATA 2'h3

`define MDB_DIV_W          16
`define MDB_SUBBITS        16
`define MDB_SUB_LAST       4'hf
`define MDB_SUB_MID        4'h7
`define MDB_BIT_LAST       3'h7

`define MDB_LINE_IDLE      1'h1
`define MDB_DE_RST         1'h0
`define MDB_DIV_RST        16'h0000

`endif

// [core/mdb_uart_pkg.sv]
// types shared by the multidrop uart and its baud generator
// assumes mdb_uart_defines.svh is on the include path
`include "mdb_uart_defines.svh"

package mdb_uart_pkg;

	typedef struct packed {
		logic       nine_bit_mode_on;
		logic       ninth_bit_tx_value;
		logic       driver_enable_polarity;
		logic [1:0] addr_match_irq_select;
		logic       parity_on;
		logic       parity_odd;
		logic [7:0] addr_compare;
	} mdb_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       is_addr;
		logic       irq;
		logic       frame_err;
		logic       parity_err;
	} mdb_rx_out_t;

	typedef enum logic [2:0] {MDB_TX_IDLE, MDB_TX_START, MDB_TX_DATA, MDB_TX_NINTH, MDB_TX_PARITY,
		MDB_TX_STOP} mdb_tx_state_t;
	typedef enum logic [2:0] {MDB_RX_IDLE, MDB_RX_START, MDB_RX_DATA, MDB_RX_NINTH, MDB_RX_PARITY,
		MDB_RX_STOP} mdb_rx_state_t;

	typedef struct packed {
		logic [`MDB_DIV_W-1:0] cnt;
		logic                  tick;
	} mdb_brg_state_t;

	typedef struct packed {
		mdb_tx_state_t tx_state;
		logic [3:0]    tx_sub;
		logic [2:0]    tx_bit;
		logic [7:0]    tx_shift;
		logic          tx_nine;
		logic          tx_ninth;
		logic          tx_par_on;
		logic          tx_par;
		logic          txd;
		logic          de;
		logic          rx_sync1;
		logic          rx_sync2;
		logic          rx_prev;
		mdb_rx_state_t rx_state;
		logic [3:0]    rx_sub;
		logic [2:0]    rx_bit;
		logic [7:0]    rx_shift;
		logic          rx_nine;
		logic          rx_ninth;
		logic          rx_par_on;
		logic          rx_par_bad;
		logic          matched;
		mdb_rx_out_t   rx_out;
	} mdb_state_t;

endpackage

// [verification/mdb_node_model.sv]
// far node on the shared line: sends frames to the uart, captures its frames
// assumes a bit time of BIT_CLKS system clocks and an idle-high line
`timescale 1ns/100ps
`default_nettype none

module mdb_node_model
#(
	parameter int BIT_CLKS = 32
)
(
	input  wire logic  sys_clk_i,
	input  wire logic  txd_i,
	output logic       rxd_o,
	output logic [9:0] frame_o,
	output int         count_o
);
	initial
	begin
		rxd_o = 1'h1;
		frame_o = '0;
		count_o = 0;
	end

	// bits holds data lsb first, then ninth bit if any, then stop
	task automatic send(input logic [9:0] bits, input int n);
		int i;
		rxd_o = 1'h0;
		repeat (BIT_CLKS) @(negedge sys_clk_i);
		for (i = 0; i < n; i++)
		begin
			rxd_o = bits[i];
			repeat (BIT_CLKS) @(negedge sys_clk_i);
		end
		rxd_o = 1'h1;
		repeat (BIT_CLKS) @(negedge sys_clk_i);
	endtask

	// ten samples: data, ninth, parity or stop, then stop or idle
	always
	begin : capture
		int i;
		@(negedge txd_i);
		repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
		for (i = 0; i < 10; i++)
		begin
			repeat (BIT_CLKS) @(posedge sys_clk_i);
			frame_o[i] <= txd_i;
		end
		count_o <= count_o + 1;
	end
endmodule

`default_nettype wire

// [verification/mdb_uart_bench.sv]
// self-checking bench of the multidrop uart against a far node model
// assumes divisor 2, so one bit is 32 clocks
`timescale 1ns/100ps
`default_nettype none

module mdb_uart_bench
	import mdb_uart_pkg::*;
;
	localparam int DIV = 2;
	localparam int BITC = 16 * DIV;
	logic        clk;
	logic        srst;
	mdb_cfg_t    cfg;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_ready;
	logic        rxd;
	logic        txd;
	logic        de;
	mdb_rx_out_t rx;
	logic [9:0]  frame;
	int          frames;
	int          fail_count;
	int          checked;
	logic [11:0] rxq[$];
	logic [15:0] div;

	initial clk = 1'h0;
	always #5 clk = ~clk;

	mdb_uart dut_u (.sys_clk_i(clk), .srst_i(srst), .cfg_i(cfg), .baud_divisor_i(div),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rxd_i(rxd),
		.txd_o(txd), .line_driver_enable_o(de), .rx_o(rx));

	mdb_node_model #(.BIT_CLKS(BITC)) node_u (.sys_clk_i(clk), .txd_i(txd), .rxd_o(rxd),
		.frame_o(frame), .count_o(frames));

	always @(negedge clk)
		if (rx.valid === 1'h1)
			rxq.push_back({rx.frame_err, rx.parity_err, rx.irq, rx.is_addr, rx.data});

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// bounded wait step; running out ends the run
	task automatic step(inout int n);
		@(negedge clk);
		n++;
		if (n > 2000)
		begin
			fail_count++;
			results();
		end
	endtask

	task automatic reset_case;
		srst = 1'h1;
		repeat (6) @(negedge clk);
		chk({txd, tx_ready, rx.valid, rx.irq, de}, 16'h0018);
		srst = 1'h0;
	endtask

	// data lsb must be 1 so the start bit width can be measured
	task automatic tx_case(input logic nine, input logic ninth, input logic pol, input logic [7:0] d);
		int n;
		int f0;
		n = 0;
		while (tx_ready !== 1'h1)
			step(n);
		cfg.nine_bit_mode_on = nine;
		cfg.ninth_bit_tx_value = ninth;
		cfg.driver_enable_polarity = pol;
		// parity on throughout: nine-bit frames must drop it
		cfg.parity_on = 1'h1;
		cfg.parity_odd = 1'h1;
		f0 = frames;
		tx_data = d;
		tx_valid = 1'h1;
		@(negedge clk);
		tx_valid = 1'h0;
		chk({txd, tx_ready, de}, {13'h0, 2'h0, ~pol});
		n = 0;
		while (txd === 1'h0)
			step(n);
		chk(16'(n), 16'(BITC));
		chk(de, {15'h0, ~pol});
		n = 0;
		while (tx_ready !== 1'h1 || frames == f0)
			step(n);
		@(negedge clk);
		chk(de, pol);
		chk(frame, {1'h1, nine ? ninth : ~^d, d});
	endtask

	task automatic rx_case(input logic [9:0] bits, input int n, input logic [9:0] exp);
		node_u.send(bits, n);
		chk(16'(rxq.size()), 16'h1);
		if (rxq.size() > 0)
			chk({4'h0, rxq.pop_front()}, {6'h0, exp});
	endtask

	// match addr, data, other addr, data under every selection
	task automatic rx_select;
		logic [3:0] irq_exp [4];
		logic [8:0] fr [4];
		int s;
		int k;
		irq_exp = '{4'hf, 4'h5, 4'h3, 4'h2};
		fr = '{9'h15a, 9'h011, 9'h15b, 9'h022};
		cfg.nine_bit_mode_on = 1'h1;
		cfg.parity_on = 1'h0;
		cfg.addr_compare = 8'h5a;
		for (s = 0; s < 4; s++)
		begin
			cfg.addr_match_irq_select = 2'(s);
			for (k = 0; k < 4; k++)
				rx_case({1'h1, fr[k]}, 10, {irq_exp[s][k], fr[k]});
		end
		cfg.nine_bit_mode_on = 1'h0;
		rx_case(10'h396, 9, {2'h2, 8'h96});
	endtask

	// divisor 3: data bit 0 must span 48 clocks; start bit length depends on tick phase
	task automatic baud_case;
		int n;
		n = 0;
		div = 16'h0003;
		tx_data = 8'h01;
		tx_valid = 1'h1;
		@(negedge clk);
		tx_valid = 1'h0;
		while (txd === 1'h0)
			step(n);
		n = 0;
		while (txd === 1'h1)
			step(n);
		chk(16'(n), 16'h0030);
		n = 0;
		while (tx_ready !== 1'h1)
			step(n);
		chk({15'h0, tx_ready}, 16'h0001);
	endtask

	initial
	begin
		fail_count = 0;
		checked = 0;
		cfg = '0;
		tx_valid = 1'h0;
		tx_data = 8'h00;
		div = 16'(DIV);
		srst = 1'h1;
		@(negedge clk);
		reset_case();
		tx_case(1'h1, 1'h1, 1'h0, 8'ha5);
		tx_case(1'h1, 1'h0, 1'h1, 8'h3b);
		tx_case(1'h0, 1'h1, 1'h0, 8'hc7);
		rx_select();
		baud_case();
		results();
	end
endmodule

`default_nettype wire
